// File: rurc_map.svh
// Purpose: Offsets, field positions, reset values and timing figures of the RTC control core.
// Assumes: Included by its bare name from every design file that needs a figure.
// Notes: Times stay in their own units; cycle and tick counts are derived from them.
`ifndef RURC_MAP_SVH
`define RURC_MAP_SVH

`define RURC_DRC_ADDR 8'h0a
`define RURC_MEC_ADDR 8'h0b
`define RURC_EVF_ADDR 8'h0c
`define RURC_BST_ADDR 8'h0d

`define RURC_DRC_PEND 7
`define RURC_DRC_OSC_HI 6
`define RURC_DRC_OSC_LO 4
`define RURC_DRC_RATE_HI 3
`define RURC_DRC_RATE_LO 0

`define RURC_MEC_SET 7
`define RURC_MEC_PER_EN 6
`define RURC_MEC_ALM_EN 5
`define RURC_MEC_UPD_EN 4
`define RURC_MEC_SQ_EN 3
`define RURC_MEC_DFMT 2
`define RURC_MEC_HR24 1
`define RURC_MEC_DST_EN 0

`define RURC_EVF_LOW_ZERO 4'h0
`define RURC_BST_VALUE 8'h80
`define RURC_BYTE_ZERO 8'h00

`define RURC_OSC_RESET 3'h0
`define RURC_OSC_RUN 3'h2
`define RURC_OSC_HOLD_HI 2'h3
`define RURC_RATE_OFF 4'h0
`define RURC_RATE_ALIAS1 4'h1
`define RURC_RATE_ALIAS2 4'h2
`define RURC_TAP_ALIAS1 4'h6
`define RURC_TAP_ALIAS2 4'h7
`define RURC_TAP_OFFSET 4'h2
`define RURC_WILDCARD 2'h3

`define RURC_CLK_HZ 250000000
`define RURC_OSC_HZ 32768
`define RURC_OSC_TICK_CYC (`RURC_CLK_HZ / `RURC_OSC_HZ)
`define RURC_PRE_UPDATE_US 244
`define RURC_PRE_UPDATE_TICKS ((`RURC_PRE_UPDATE_US * `RURC_OSC_HZ + 999999) / 1000000)
`define RURC_FIRST_UPDATE_MS 500
`define RURC_DIV_PRESET 15'((`RURC_FIRST_UPDATE_MS * `RURC_OSC_HZ) / 1000)
`define RURC_DIV_LAST 15'h7fff
`define RURC_PEND_START 15'(`RURC_OSC_HZ - `RURC_PRE_UPDATE_TICKS)

`define RURC_SYNC_W 13

`endif

// File: rurc_pkg.sv
// Purpose: Types shared by the RTC control core.
// Assumes: Figures live in rurc_map.svh.
// Notes: Only types are kept here.
package rurc_pkg;
    typedef logic [7:0] rurc_byte_t;
    typedef enum logic [1:0] {
        RURC_OSC_STOPPED,
        RURC_OSC_HELD,
        RURC_OSC_COUNTING
    } rurc_osc_mode_t;
endpackage : rurc_pkg

// File: rurc_sync.sv
// Purpose: Two-stage synchroniser for the bus pins and the reset pin.
// Assumes: Inputs are asynchronous to clk.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
`include "rurc_map.svh"
module rurc_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`RURC_SYNC_W-1:0] asyncIn,
    output logic [`RURC_SYNC_W-1:0] syncOut
);
    logic [`RURC_SYNC_W-1:0] meta_r;
    logic [`RURC_SYNC_W-1:0] stable_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            stable_r <= '0;
        end else begin
            meta_r <= asyncIn;
            stable_r <= meta_r;
        end
    end

    assign syncOut = stable_r;
endmodule : rurc_sync

// File: rurc_core.sv
// Purpose: RTC control core: divider chain, rate taps, update cycle, alarm match, control registers.
// Assumes: Calendar counters, user copy and general RAM sit in other blocks fed by the strobes.
// Notes: sys_rst is power-on; resetPinN is the device reset pin and clears only the interrupt and square-wave enables and the event flags.
`timescale 1ns/1ps
`include "rurc_map.svh"
// Operation
// - Chain counts only with oscillator bits 010; the oscillator also runs with 11X.
// - Pattern 11X runs oscillator, holds chain reset; others stop oscillator.
// - First update comes 500 ms after the running pattern is written.
// - Rate bits pick one of 13 taps or off; one selector for both uses.
// - Periodic rate spans 500 ms down to 122 microseconds.
// - Rate change alters both square wave and periodic rate; separate enables.
// - Square pin toggles when enabled, else low; pin reset clears enable.
// - Update cycle runs every second regardless of set mode.
// - Set mode freezes user copy while internal copy keeps advancing.
// - Update compares three alarm bytes; top bits 11 act as wildcard.
// - Update-ended event follows every update cycle.
// - Pending flag rises 244 microseconds before each update transfer.
// - Pending flag read-only, pin-reset immune; writing set one clears it.
// - Rate bits are read/write and survive pin reset.
// - Set bit is read/write, untouched by pin reset and internal logic.
// - Periodic enable gates periodic flag to interrupt; flag sets regardless.
// - Alarm enable gates alarm flag; alarm event each matching second.
// - Update-ended enable cleared by pin reset or set bit rising.
// - Data format bit: one binary, zero BCD; never changed internally.
// - Hour format bit: one 24-hour, zero 12-hour; survives pin reset.
// - Daylight saving enable steers the spring and autumn hour jumps.
// - Control registers stay reachable at all times except during pin reset, updates included.
// - Interrupt line low while any flag meets its enable; summary mirrors it.
// - Reading the flag register clears the flags it returned set; pin reset clears all three event flags.
module rurc_core #(
    parameter int unsigned OSC_TICK_CYC = `RURC_OSC_TICK_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic resetPinN,
    input wire logic chipSelN,
    input wire logic addrStrobe,
    input wire logic dataStrobe,
    input wire logic readNotWrite,
    input wire rurc_pkg::rurc_byte_t adIn,
    output rurc_pkg::rurc_byte_t adOut,
    output logic adOe,
    output logic irqOut,
    output logic irqOe,
    output logic squareOutPin,
    output logic oscRunning,
    output logic updateAdvance,
    output logic userCopyLoad,
    output logic dataFormatSel,
    output logic hour24Sel,
    output logic daylightSavingEnable,
    input wire rurc_pkg::rurc_byte_t timeSec,
    input wire rurc_pkg::rurc_byte_t timeMin,
    input wire rurc_pkg::rurc_byte_t timeHour,
    input wire rurc_pkg::rurc_byte_t alarmSec,
    input wire rurc_pkg::rurc_byte_t alarmMin,
    input wire rurc_pkg::rurc_byte_t alarmHour
);
    import rurc_pkg::*;

    // Pin synchronisation.
    logic [`RURC_SYNC_W-1:0] syncIn;
    logic [`RURC_SYNC_W-1:0] syncOut;
    logic pinRstN;
    logic csN;
    logic asLvl;
    logic dsLvl;
    logic rdLvl;
    rurc_byte_t adSync;

    assign syncIn = {resetPinN, chipSelN, addrStrobe, dataStrobe, readNotWrite, adIn};

    rurc_sync i_rurc_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(syncIn),
        .syncOut(syncOut)
    );

    assign pinRstN = syncOut[12];
    assign csN = syncOut[11];
    assign asLvl = syncOut[10];
    assign dsLvl = syncOut[9];
    assign rdLvl = syncOut[8];
    assign adSync = syncOut[7:0];

    // Bus state.
    logic asPrev_r, asPrev_nxt;
    logic dsPrev_r, dsPrev_nxt;
    rurc_byte_t addr_r, addr_nxt;
    rurc_byte_t readData_r, readData_nxt;
    logic driving_r, driving_nxt;
    logic asFall;
    logic dsRise;
    logic dsFall;
    logic busOk;
    logic readStart;
    logic accessEnd;
    logic writeDrc;
    logic writeMec;
    logic clearFlags;
    logic [2:0] flagSnap;

    // Control registers.
    logic updatePendingFlag_r, updatePendingFlag_nxt;
    logic [2:0] oscCtl_r, oscCtl_nxt;
    logic [3:0] rateSel_r, rateSel_nxt;
    logic setMode_r, setMode_nxt;
    logic periodicIrqEnable_r, periodicIrqEnable_nxt;
    logic alarmIrqEnable_r, alarmIrqEnable_nxt;
    logic updateEndIrqEnable_r, updateEndIrqEnable_nxt;
    logic squareOutEnable_r, squareOutEnable_nxt;
    logic dataFormatSel_r, dataFormatSel_nxt;
    logic hour24Sel_r, hour24Sel_nxt;
    logic daylightSavingEnable_r, daylightSavingEnable_nxt;

    // Timebase and events.
    logic [12:0] tickCnt_r, tickCnt_nxt;
    logic [14:0] divCnt_r, divCnt_nxt;
    logic tapPrev_r, tapPrev_nxt;
    logic squareOut_r, squareOut_nxt;
    logic updateAdvance_r, updateAdvance_nxt;
    logic userCopyLoad_r, userCopyLoad_nxt;
    logic updateDone_r, updateDone_nxt;
    logic periodicEventFlag_r, periodicEventFlag_nxt;
    logic alarmEventFlag_r, alarmEventFlag_nxt;
    logic updateEndFlag_r, updateEndFlag_nxt;
    rurc_osc_mode_t oscMode;
    logic oscTick;
    logic chainTick;
    logic updateTick;
    logic pendingStart;
    logic [14:0] divNext;
    logic [3:0] tapIdx;
    logic tapOn;
    logic tapLvl;
    logic periodicEvent;
    logic alarmEvent;
    logic updateEndEvent;
    logic summaryIrqFlag;
    logic [2:0] byteHit;
    rurc_byte_t timeBytes [3];
    rurc_byte_t alarmBytes [3];

    assign asFall = asPrev_r & ~asLvl;
    assign dsRise = ~dsPrev_r & dsLvl;
    assign dsFall = dsPrev_r & ~dsLvl;
    assign busOk = pinRstN & ~csN;
    assign readStart = dsRise & busOk & rdLvl;
    assign accessEnd = dsFall & busOk;
    assign writeDrc = accessEnd & ~rdLvl & (addr_r == `RURC_DRC_ADDR);
    assign writeMec = accessEnd & ~rdLvl & (addr_r == `RURC_MEC_ADDR);
    assign clearFlags = accessEnd & rdLvl & (addr_r == `RURC_EVF_ADDR);
    assign flagSnap = {readData_r[6], readData_r[5], readData_r[4]};

    always_comb begin
        asPrev_nxt = asLvl;
        dsPrev_nxt = dsLvl;
        addr_nxt = addr_r;
        readData_nxt = readData_r;
        driving_nxt = driving_r;
        if (asFall && busOk) begin
            addr_nxt = adSync;
        end
        if (readStart) begin
            driving_nxt = 1'b1;
            unique case (addr_r)
                `RURC_DRC_ADDR: readData_nxt = {updatePendingFlag_r, oscCtl_r, rateSel_r};
                `RURC_MEC_ADDR: readData_nxt = {setMode_r, periodicIrqEnable_r,
                    alarmIrqEnable_r, updateEndIrqEnable_r, squareOutEnable_r,
                    dataFormatSel_r, hour24Sel_r, daylightSavingEnable_r};
                `RURC_EVF_ADDR: readData_nxt = {summaryIrqFlag, periodicEventFlag_r,
                    alarmEventFlag_r, updateEndFlag_r, `RURC_EVF_LOW_ZERO};
                `RURC_BST_ADDR: readData_nxt = `RURC_BST_VALUE;
                default: begin
                    readData_nxt = `RURC_BYTE_ZERO;
                    driving_nxt = 1'b0;
                end
            endcase
        end
        if (dsFall || !busOk) begin
            driving_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            asPrev_r <= 1'b0;
            dsPrev_r <= 1'b0;
            addr_r <= `RURC_BYTE_ZERO;
            readData_r <= `RURC_BYTE_ZERO;
            driving_r <= 1'b0;
        end else begin
            asPrev_r <= asPrev_nxt;
            dsPrev_r <= dsPrev_nxt;
            addr_r <= addr_nxt;
            readData_r <= readData_nxt;
            driving_r <= driving_nxt;
        end
    end

    // Control register writes; rate, oscillator, set and format bits ignore the reset pin.
    always_comb begin
        oscCtl_nxt = oscCtl_r;
        rateSel_nxt = rateSel_r;
        setMode_nxt = setMode_r;
        periodicIrqEnable_nxt = periodicIrqEnable_r;
        alarmIrqEnable_nxt = alarmIrqEnable_r;
        updateEndIrqEnable_nxt = updateEndIrqEnable_r;
        squareOutEnable_nxt = squareOutEnable_r;
        dataFormatSel_nxt = dataFormatSel_r;
        hour24Sel_nxt = hour24Sel_r;
        daylightSavingEnable_nxt = daylightSavingEnable_r;
        if (writeDrc) begin
            oscCtl_nxt = adSync[`RURC_DRC_OSC_HI:`RURC_DRC_OSC_LO];
            rateSel_nxt = adSync[`RURC_DRC_RATE_HI:`RURC_DRC_RATE_LO];
        end
        if (writeMec) begin
            setMode_nxt = adSync[`RURC_MEC_SET];
            periodicIrqEnable_nxt = adSync[`RURC_MEC_PER_EN];
            alarmIrqEnable_nxt = adSync[`RURC_MEC_ALM_EN];
            updateEndIrqEnable_nxt = adSync[`RURC_MEC_UPD_EN] &
                ~(adSync[`RURC_MEC_SET] & ~setMode_r);
            squareOutEnable_nxt = adSync[`RURC_MEC_SQ_EN];
            dataFormatSel_nxt = adSync[`RURC_MEC_DFMT];
            hour24Sel_nxt = adSync[`RURC_MEC_HR24];
            daylightSavingEnable_nxt = adSync[`RURC_MEC_DST_EN];
        end
        if (!pinRstN) begin
            periodicIrqEnable_nxt = 1'b0;
            alarmIrqEnable_nxt = 1'b0;
            updateEndIrqEnable_nxt = 1'b0;
            squareOutEnable_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oscCtl_r <= `RURC_OSC_RESET;
            rateSel_r <= `RURC_RATE_OFF;
            setMode_r <= 1'b0;
            periodicIrqEnable_r <= 1'b0;
            alarmIrqEnable_r <= 1'b0;
            updateEndIrqEnable_r <= 1'b0;
            squareOutEnable_r <= 1'b0;
            dataFormatSel_r <= 1'b0;
            hour24Sel_r <= 1'b0;
            daylightSavingEnable_r <= 1'b0;
        end else begin
            oscCtl_r <= oscCtl_nxt;
            rateSel_r <= rateSel_nxt;
            setMode_r <= setMode_nxt;
            periodicIrqEnable_r <= periodicIrqEnable_nxt;
            alarmIrqEnable_r <= alarmIrqEnable_nxt;
            updateEndIrqEnable_r <= updateEndIrqEnable_nxt;
            squareOutEnable_r <= squareOutEnable_nxt;
            dataFormatSel_r <= dataFormatSel_nxt;
            hour24Sel_r <= hour24Sel_nxt;
            daylightSavingEnable_r <= daylightSavingEnable_nxt;
        end
    end

    // Oscillator mode decode.
    always_comb begin
        if (oscCtl_r == `RURC_OSC_RUN) begin
            oscMode = RURC_OSC_COUNTING;
        end else if (oscCtl_r[2:1] == `RURC_OSC_HOLD_HI) begin
            oscMode = RURC_OSC_HELD;
        end else begin
            oscMode = RURC_OSC_STOPPED;
        end
    end

    assign oscTick = (oscMode != RURC_OSC_STOPPED) && (tickCnt_r == 13'(OSC_TICK_CYC - 1));
    assign chainTick = oscTick && (oscMode == RURC_OSC_COUNTING);
    assign divNext = divCnt_r + 15'h1;
    assign updateTick = chainTick && (divCnt_r == `RURC_DIV_LAST);
    assign pendingStart = chainTick && (divNext == `RURC_PEND_START) && !setMode_r;

    // Tap select; codes 1 and 2 reuse the taps of codes 8 and 9.
    always_comb begin
        unique case (rateSel_r)
            `RURC_RATE_OFF: tapIdx = 4'h0;
            `RURC_RATE_ALIAS1: tapIdx = `RURC_TAP_ALIAS1;
            `RURC_RATE_ALIAS2: tapIdx = `RURC_TAP_ALIAS2;
            default: tapIdx = rateSel_r - `RURC_TAP_OFFSET;
        endcase
    end

    assign tapOn = (rateSel_r != `RURC_RATE_OFF) && (oscMode == RURC_OSC_COUNTING);
    assign tapLvl = tapOn & divCnt_r[tapIdx];
    assign periodicEvent = tapLvl & ~tapPrev_r;

    // Alarm match with the wildcard code on each byte.
    assign timeBytes[0] = timeSec;
    assign timeBytes[1] = timeMin;
    assign timeBytes[2] = timeHour;
    assign alarmBytes[0] = alarmSec;
    assign alarmBytes[1] = alarmMin;
    assign alarmBytes[2] = alarmHour;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_match
            assign byteHit[gi] = (alarmBytes[gi][7:6] == `RURC_WILDCARD) ||
                (alarmBytes[gi] == timeBytes[gi]);
        end
    endgenerate

    assign alarmEvent = updateDone_r & (&byteHit);
    assign updateEndEvent = updateDone_r;

    always_comb begin
        tickCnt_nxt = tickCnt_r + 13'h1;
        if (oscMode == RURC_OSC_STOPPED || oscTick) begin
            tickCnt_nxt = 13'h0;
        end
        divCnt_nxt = divCnt_r;
        if (oscMode != RURC_OSC_COUNTING) begin
            divCnt_nxt = `RURC_DIV_PRESET;
        end else if (chainTick) begin
            divCnt_nxt = divNext;
        end
        tapPrev_nxt = tapLvl;
        squareOut_nxt = tapLvl & squareOutEnable_r;
        updateAdvance_nxt = updateTick;
        userCopyLoad_nxt = updateTick & ~setMode_r;
        updateDone_nxt = updateAdvance_r;
        updatePendingFlag_nxt = updatePendingFlag_r;
        if (pendingStart) begin
            updatePendingFlag_nxt = 1'b1;
        end
        if (updateTick || (writeMec && adSync[`RURC_MEC_SET])) begin
            updatePendingFlag_nxt = 1'b0;
        end
        periodicEventFlag_nxt = (periodicEventFlag_r & ~(clearFlags & flagSnap[2])) |
            periodicEvent;
        alarmEventFlag_nxt = (alarmEventFlag_r & ~(clearFlags & flagSnap[1])) | alarmEvent;
        updateEndFlag_nxt = (updateEndFlag_r & ~(clearFlags & flagSnap[0])) | updateEndEvent;
        if (!pinRstN) begin
            periodicEventFlag_nxt = 1'b0;
            alarmEventFlag_nxt = 1'b0;
            updateEndFlag_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tickCnt_r <= 13'h0;
            divCnt_r <= `RURC_DIV_PRESET;
            tapPrev_r <= 1'b0;
            squareOut_r <= 1'b0;
            updateAdvance_r <= 1'b0;
            userCopyLoad_r <= 1'b0;
            updateDone_r <= 1'b0;
            updatePendingFlag_r <= 1'b0;
            periodicEventFlag_r <= 1'b0;
            alarmEventFlag_r <= 1'b0;
            updateEndFlag_r <= 1'b0;
        end else begin
            tickCnt_r <= tickCnt_nxt;
            divCnt_r <= divCnt_nxt;
            tapPrev_r <= tapPrev_nxt;
            squareOut_r <= squareOut_nxt;
            updateAdvance_r <= updateAdvance_nxt;
            userCopyLoad_r <= userCopyLoad_nxt;
            updateDone_r <= updateDone_nxt;
            updatePendingFlag_r <= updatePendingFlag_nxt;
            periodicEventFlag_r <= periodicEventFlag_nxt;
            alarmEventFlag_r <= alarmEventFlag_nxt;
            updateEndFlag_r <= updateEndFlag_nxt;
        end
    end

    assign summaryIrqFlag = (periodicEventFlag_r & periodicIrqEnable_r) |
        (alarmEventFlag_r & alarmIrqEnable_r) |
        (updateEndFlag_r & updateEndIrqEnable_r);

    // The interrupt pin is open drain: it only ever pulls low.
    assign irqOut = 1'b0;
    assign irqOe = summaryIrqFlag;
    assign adOut = readData_r;
    assign adOe = driving_r;
    assign squareOutPin = squareOut_r;
    assign oscRunning = (oscMode != RURC_OSC_STOPPED);
    assign updateAdvance = updateAdvance_r;
    assign userCopyLoad = userCopyLoad_r;
    assign dataFormatSel = dataFormatSel_r;
    assign hour24Sel = hour24Sel_r;
    // The calendar block applies the April and October hour jumps while this is set.
    assign daylightSavingEnable = daylightSavingEnable_r;
endmodule : rurc_core

// File: rurc_core_asserts.sv
// Purpose: Concurrent checks on the ports of rurc_core.
// Assumes: One clock domain; sys_rst disables every check.
// Notes: Pin-reset checks allow for the two-stage synchroniser.
`timescale 1ns/1ps
`include "rurc_map.svh"
module rurc_core_asserts #(
    parameter int unsigned OSC_TICK_CYC = `RURC_OSC_TICK_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic resetPinN,
    input wire logic chipSelN,
    input wire rurc_pkg::rurc_byte_t adOut,
    input wire logic adOe,
    input wire logic irqOut,
    input wire logic irqOe,
    input wire logic squareOutPin,
    input wire logic oscRunning,
    input wire logic updateAdvance,
    input wire logic userCopyLoad
);
    import rurc_pkg::*;
    localparam int unsigned MinGap = 16384 * OSC_TICK_CYC - 1;
    logic [31:0] gapCnt_r;
    logic [31:0] gapCnt_nxt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Counts clocks since the last update pulse and saturates.
    always_comb begin
        gapCnt_nxt = updateAdvance ? 32'h0 : gapCnt_r + {31'h0, ~&gapCnt_r};
    end
    always_ff @(posedge clk) begin
        gapCnt_r <= sys_rst ? 32'h0 : gapCnt_nxt;
    end
    property p_irq_od; irqOut == 1'b0; endproperty
    a_irq_od: assert property (p_irq_od) else $error("irq pin driven high");
    property p_pin_irq; !resetPinN [*6] |-> !irqOe; endproperty
    a_pin_irq: assert property (p_pin_irq) else $error("irq held in pin reset");
    property p_pin_sq; !resetPinN [*6] |-> !squareOutPin; endproperty
    a_pin_sq: assert property (p_pin_sq) else $error("square high in pin reset");
    property p_cs_bus; chipSelN [*6] |-> !adOe; endproperty
    a_cs_bus: assert property (p_cs_bus) else $error("bus driven unselected");
    property p_copy; userCopyLoad |-> updateAdvance; endproperty
    a_copy: assert property (p_copy) else $error("copy load without update");
    property p_adv_pulse; updateAdvance |=> !updateAdvance [*8]; endproperty
    a_adv_pulse: assert property (p_adv_pulse) else $error("update pulse too long");
    property p_osc; !oscRunning |-> !updateAdvance; endproperty
    a_osc: assert property (p_osc) else $error("update with oscillator off");
    property p_gap; updateAdvance |-> gapCnt_r >= MinGap; endproperty
    a_gap: assert property (p_gap) else $error("update too early");
    property p_rd_stable; adOe && $past(adOe) |-> $stable(adOut); endproperty
    a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
    c_update: cover property (updateAdvance);
    c_irq: cover property ($rose(irqOe));
    c_read: cover property ($rose(adOe));
endmodule : rurc_core_asserts

bind rurc_core rurc_core_asserts #(.OSC_TICK_CYC(OSC_TICK_CYC)) i_rurc_core_asserts (
    .clk(clk), .sys_rst(sys_rst), .resetPinN(resetPinN), .chipSelN(chipSelN),
    .adOut(adOut), .adOe(adOe), .irqOut(irqOut), .irqOe(irqOe),
    .squareOutPin(squareOutPin), .oscRunning(oscRunning),
    .updateAdvance(updateAdvance), .userCopyLoad(userCopyLoad)
);

// File: rurc_host_model.sv
// Purpose: Host processor on the multiplexed address/data bus.
// Assumes: Pins change at the falling clock edge.
// Notes: Each strobe level lasts several clocks so the synchroniser sees it.
`timescale 1ns/1ps
module rurc_host_model (
    input wire logic clk,
    output logic chipSelN,
    output logic addrStrobe,
    output logic dataStrobe,
    output logic readNotWrite,
    output rurc_pkg::rurc_byte_t adIn,
    input wire rurc_pkg::rurc_byte_t adOut,
    input wire logic adOe
);
    import rurc_pkg::*;
    initial begin
        chipSelN = 1'b1;
        addrStrobe = 1'b0;
        dataStrobe = 1'b0;
        readNotWrite = 1'b1;
        adIn = 8'h00;
    end
    // One bus cycle; a released bus shows the inverse of its last value.
    task automatic access(input logic rd, input rurc_byte_t a, input rurc_byte_t wd,
                          output rurc_byte_t q, output logic seen);
        seen = 1'b0;
        q = 8'h00;
        @(negedge clk);
        chipSelN <= 1'b0;
        addrStrobe <= 1'b1;
        adIn <= a;
        repeat (4) @(negedge clk);
        addrStrobe <= 1'b0;
        readNotWrite <= rd;
        repeat (4) @(negedge clk);
        dataStrobe <= 1'b1;
        adIn <= rd ? ~a : wd;
        repeat (6) begin
            @(negedge clk);
            if (adOe === 1'b1) begin
                seen = 1'b1;
                q = adOut;
            end
        end
        @(negedge clk);
        dataStrobe <= 1'b0;
        repeat (5) @(negedge clk);
        chipSelN <= 1'b1;
        readNotWrite <= 1'b1;
        adIn <= ~adIn;
    endtask : access
endmodule : rurc_host_model

// File: rurc_core_tb_top.sv
// Purpose: Self-checking bench for rurc_core.
// Assumes: Oscillator tick shortened to 4 clocks, so half a second is 65536 clocks.
// Notes: One update cycle is reached; its timing, pending flag and alarm are checked.
`timescale 1ns/1ps
module rurc_core_tb_top;
    import rurc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic resetPinN = 1'b1;
    logic chipSelN, addrStrobe, dataStrobe, readNotWrite;
    rurc_byte_t adIn, adOut;
    logic adOe, irqOut, irqOe, squareOutPin, oscRunning, updateAdvance, userCopyLoad;
    logic dataFormatSel, hour24Sel, daylightSavingEnable, sqPrev, copySeen;
    rurc_byte_t timeSec = 8'h12, timeMin = 8'h34, timeHour = 8'h05;
    rurc_byte_t alarmSec = 8'h12, alarmMin = 8'hc7, alarmHour = 8'h05;
    int errorCnt = 0, nTests = 0, cyc = 0, updCyc = 0, togg = 0;
    always #2 clk = ~clk;
    rurc_core #(.OSC_TICK_CYC(4)) i_rurc_core (
        .clk(clk), .sys_rst(sys_rst), .resetPinN(resetPinN), .chipSelN(chipSelN),
        .addrStrobe(addrStrobe), .dataStrobe(dataStrobe), .readNotWrite(readNotWrite),
        .adIn(adIn), .adOut(adOut), .adOe(adOe), .irqOut(irqOut), .irqOe(irqOe),
        .squareOutPin(squareOutPin), .oscRunning(oscRunning),
        .updateAdvance(updateAdvance), .userCopyLoad(userCopyLoad),
        .dataFormatSel(dataFormatSel), .hour24Sel(hour24Sel),
        .daylightSavingEnable(daylightSavingEnable), .timeSec(timeSec),
        .timeMin(timeMin), .timeHour(timeHour), .alarmSec(alarmSec),
        .alarmMin(alarmMin), .alarmHour(alarmHour)
    );
    rurc_host_model i_rurc_host_model (
        .clk(clk), .chipSelN(chipSelN), .addrStrobe(addrStrobe),
        .dataStrobe(dataStrobe), .readNotWrite(readNotWrite), .adIn(adIn),
        .adOut(adOut), .adOe(adOe)
    );
    task automatic testDone;
        $display("checks %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : testDone
    always @(negedge clk) begin
        cyc <= cyc + 1;
        sqPrev <= squareOutPin;
        if (squareOutPin !== sqPrev) togg <= togg + 1;
        if (updateAdvance === 1'b1 && updCyc == 0) begin
            updCyc <= cyc;
            copySeen <= userCopyLoad;
        end
        if (cyc == 90000) begin
            errorCnt++;
            $display("[ERR] %0t timeout", $time);
            testDone();
        end
    end
    task automatic chk8(input rurc_byte_t got, input rurc_byte_t exp, input string m);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp, input string m);
        chk8({7'h0, got}, {7'h0, exp}, m);
    endtask : chk1
    task automatic wr(input rurc_byte_t a, input rurc_byte_t d);
        rurc_byte_t q;
        logic s;
        i_rurc_host_model.access(1'b0, a, d, q, s);
    endtask : wr
    task automatic rd(input rurc_byte_t a, input rurc_byte_t e, input string m, input logic on);
        rurc_byte_t q;
        logic s;
        i_rurc_host_model.access(1'b1, a, 8'h00, q, s);
        chk1(s, on, m);
        if (on) chk8(q, e, m);
    endtask : rd
    initial begin
        int n0, b, t0;
        repeat (8) @(negedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge clk);
        rd(8'h0d, 8'h80, "status", 1'b1);
        rd(8'h0a, 8'h00, "rate reset", 1'b1);
        rd(8'h0b, 8'h00, "mode reset", 1'b1);
        rd(8'h0e, 8'h00, "unmapped", 1'b0);
        wr(8'h0b, 8'h4f);
        rd(8'h0b, 8'h4f, "mode", 1'b1);
        chk8({5'h0, dataFormatSel, hour24Sel, daylightSavingEnable}, 8'h07, "fmt");
        wr(8'h0a, 8'h23);
        rd(8'h0a, 8'h23, "rate", 1'b1);
        repeat (40) @(negedge clk);
        chk1(irqOe, 1'b1, "periodic irq");
        rd(8'h0c, 8'hc0, "flags", 1'b1);
        resetPinN <= 1'b0;
        repeat (8) @(negedge clk);
        chk8({6'h0, irqOe, squareOutPin}, 8'h00, "pin reset");
        resetPinN <= 1'b1;
        repeat (4) @(negedge clk);
        rd(8'h0b, 8'h07, "mode pin reset", 1'b1);
        rd(8'h0a, 8'h23, "rate pin reset", 1'b1);
        $display("register test done");
        wr(8'h0b, 8'h3f);
        for (int c = 0; c < 16; c++) begin
            wr(8'h0a, 8'h20 | 8'(c));
            n0 = togg;
            repeat (256) @(negedge clk);
            b = (c == 1) ? 6 : (c == 2) ? 7 : c - 2;
            chk1((c == 0) ? (togg == n0) : (togg - n0 - (64 >> b)) inside {-1, 0, 1}, 1'b1,
                 "tap");
        end
        wr(8'h0b, 8'h37);
        n0 = togg;
        repeat (64) @(negedge clk);
        chk1(togg == n0 && squareOutPin === 1'b0, 1'b1, "square off");
        for (int o = 0; o < 8; o++) begin
            wr(8'h0a, {1'b0, 3'(o), 4'h3});
            chk1(oscRunning, o == 2 || o >= 6, "osc mode");
        end
        $display("rate test done");
        wr(8'h0a, 8'h23);
        t0 = cyc;
        while (cyc < t0 + 65507) @(negedge clk);
        rd(8'h0a, 8'ha3, "pending", 1'b1);
        for (int k = 0; k < 200 && updCyc == 0; k++) @(negedge clk);
        chk1((updCyc - t0) inside {[65526:65542]}, 1'b1, "first update");
        chk1(copySeen, 1'b1, "copy load");
        repeat (8) @(negedge clk);
        chk1(irqOe, 1'b1, "update irq");
        rd(8'h0c, 8'hf0, "update flags", 1'b1);
        wr(8'h0b, 8'hb7);
        rd(8'h0b, 8'ha7, "set mode", 1'b1);
        $display("update test done");
        testDone();
    end
endmodule : rurc_core_tb_top
